// ==== hdl/atc_ctl.sv ====
// Notes on behaviour
// - any write to either control register aborts the running sequence
// - without fast clear a flag clears only by writing one to it
// - fast clear, compare off: reading result n clears flag n
// - fast clear, compare on: writing result n clears flag n
// - level and polarity bits pick falling, rising, low or high trigger
// - trigger enable arms triggering and enables channel input buffer when trig_src_channel_in is set
// - sequence irq enable requests interrupt while sequence flag set
// - compare irq enable requests interrupt when compare-enabled flag sets
// - results unsigned; justify bit zero left, one right
// - bits six to three give sequence length, reset gives four
// - fixed mode: k-th conversion goes to result register k
// - fifo mode: slot counter keeps running and wraps after last
// - slot counter readable in status register
// - abort or new start clears slot counter, also in fifo mode
// - fifo mode disables all compare and compare interrupt
// - freeze field decides response to debug breakpoint
// - freeze codes: run, reserved, finish then freeze, freeze now
// - length code zero or above six means six conversions
`timescale 1ns/1ps
module atc_ctl
  import atc_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic              ext_trig_in,
  input  wire logic              trig_src_channel_in,
  input  wire logic              freeze_in,
  input  wire logic              conv_done_in,
  input  wire logic [RES_BITS-1:0] conv_data_in,
  input  wire logic              conv_match_in,
  output logic                   conv_start_out,
  output logic                   conv_abort_out,
  output logic                   conv_hold_out,
  output logic                   dig_buf_en_out,
  output logic                   irq_out
);

  atc_res_if #(.DEPTH(NUM_SLOTS), .WIDTH(DATA_W), .AW(SLOT_W)) res ();

  atc_result_mem #(.DEPTH(NUM_SLOTS), .WIDTH(DATA_W)) u_mem (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .res         (res.mem)
  );

  logic [7:0]           trig_ctl_ff;
  logic [7:0]           fmt_ctl_ff;
  logic [NUM_SLOTS-1:0] cmp_en_ff;
  logic [NUM_SLOTS-1:0] ccf_ff;
  logic [1:0]           irq_stat_ff;
  logic [1:0]           irq_mask_ff;
  logic [SLOT_W-1:0]    slot_ff;
  logic [SLOT_W-1:0]    conv_idx_ff;
  atc_state_t           state_ff;
  atc_state_t           nxt_state;
  logic                 trig_meta_ff;
  logic                 trig_sync_ff;
  logic                 trig_prev_ff;
  logic                 conv_start_ff;
  logic                 conv_abort_ff;
  logic                 conv_hold_ff;
  logic                 dig_buf_ff;
  logic                 irq_ff;
  logic [DATA_W-1:0]    rd_data_ff;
  logic                 res_sel_ff;
  logic                 start_pulse;

  // address decode
  wire wr_trig  = reg_wr_in && (reg_addr_in == OFS_TRIG_CTL);
  wire wr_fmt   = reg_wr_in && (reg_addr_in == OFS_FMT_CTL);
  wire wr_start = reg_wr_in && (reg_addr_in == OFS_START);
  wire wr_flags = reg_wr_in && (reg_addr_in == OFS_FLAGS);
  wire wr_cmp   = reg_wr_in && (reg_addr_in == OFS_CMP_EN);
  wire wr_istat = reg_wr_in && (reg_addr_in == OFS_IRQ_STAT);
  wire wr_imask = reg_wr_in && (reg_addr_in == OFS_IRQ_MASK);
  wire res_hit  = (reg_addr_in >= OFS_RES_BASE)
               && (reg_addr_in < OFS_RES_BASE + ADDR_W'(NUM_SLOTS));
  wire [SLOT_W-1:0] res_idx = SLOT_W'(reg_addr_in - OFS_RES_BASE);
  wire rd_res   = reg_rd_in && res_hit;
  wire wr_res   = reg_wr_in && res_hit;

  // abort on trigger or format control write or new start
  wire abort_req = wr_trig || wr_fmt || wr_start;

  // decoded control fields
  wire fast_clr   = trig_ctl_ff[BIT_FAST_CLR];
  wire ext_en     = trig_ctl_ff[BIT_EXT_TRIG];
  wire trig_level = trig_ctl_ff[BIT_LEVEL];
  wire trig_pol   = trig_ctl_ff[BIT_POL];
  wire seq_ie     = trig_ctl_ff[BIT_SEQ_IE];
  wire fifo_mode  = fmt_ctl_ff[BIT_FIFO];
  wire justify_r  = fmt_ctl_ff[BIT_JUSTIFY];
  wire [SLOT_W-1:0] seq_len = atc_seq_len(fmt_ctl_ff[SEQ_MSB:SEQ_LSB]);
  wire atc_frz_t  frz_mode  = atc_frz_t'(fmt_ctl_ff[FRZ_MSB:FRZ_LSB]);

  // fifo mode hides every compare enable
  wire [NUM_SLOTS-1:0] cmp_en_eff = fifo_mode ? '0 : cmp_en_ff;
  wire cmp_ie_eff = trig_ctl_ff[BIT_CMP_IE] && !fifo_mode;

  // trigger sensitivity from level and polarity bits
  wire trig_rise  = !trig_prev_ff && trig_sync_ff;
  wire trig_fall  = trig_prev_ff && !trig_sync_ff;
  wire trig_edge  = trig_pol ? trig_rise : trig_fall;
  wire trig_lvl   = (trig_sync_ff == trig_pol);
  wire trig_event = ext_en && (trig_level ? trig_lvl : trig_edge);

  // breakpoint response
  wire frz_stop_next = freeze_in && (frz_mode == FRZ_FINISH || frz_mode == FRZ_NOW);
  wire frz_now       = freeze_in && (frz_mode == FRZ_NOW);

  // conversion completion and storage
  wire last_conv = (conv_idx_ff == seq_len - 3'd1);
  wire store_en  = conv_done_in && (state_ff == ST_WAIT) && !abort_req;
  wire seq_done  = store_en && last_conv;
  wire [DATA_W-1:0] res_word = justify_r ? {6'h00, conv_data_in}
                                         : {conv_data_in, 6'h00};

  // conversion flag set and clear vectors
  wire [NUM_SLOTS-1:0] slot_bit = atc_onehot(slot_ff);
  wire [NUM_SLOTS-1:0] idx_bit  = atc_onehot(res_idx);
  wire [NUM_SLOTS-1:0] set_vec  = store_en
                                ? slot_bit & (~cmp_en_eff | {NUM_SLOTS{conv_match_in}})
                                : '0;
  wire [NUM_SLOTS-1:0] clr_w1c  = (!fast_clr && wr_flags)
                                ? reg_wdata_in[NUM_SLOTS-1:0] : '0;
  wire [NUM_SLOTS-1:0] clr_rd   = (fast_clr && rd_res) ? idx_bit & ~cmp_en_eff : '0;
  wire [NUM_SLOTS-1:0] clr_wr   = (fast_clr && wr_res) ? idx_bit & cmp_en_eff : '0;
  wire [NUM_SLOTS-1:0] nxt_ccf  = set_vec | (ccf_ff & ~(clr_w1c | clr_rd | clr_wr));
  wire cmp_evt = |(set_vec & cmp_en_eff);

  // interrupt status, set wins over write-one clear
  wire [1:0] istat_clr = wr_istat ? reg_wdata_in[1:0] : 2'h0;
  wire [1:0] nxt_istat = (irq_stat_ff & ~istat_clr) | {cmp_evt, seq_done};
  wire [1:0] irq_en    = {cmp_ie_eff, seq_ie};
  wire       nxt_irq   = |(irq_stat_ff & irq_mask_ff & irq_en);

  // slot counter: fixed mode follows the conversion index, fifo wraps
  wire [SLOT_W-1:0] slot_inc = (slot_ff == SLOT_W'(NUM_SLOTS - 1)) ? '0
                                                                  : SLOT_W'(slot_ff + 3'd1);
  wire [SLOT_W-1:0] nxt_slot = abort_req ? '0
                             : !store_en ? slot_ff
                             : fifo_mode ? slot_inc
                             : last_conv ? '0 : SLOT_W'(slot_ff + 3'd1);
  wire [SLOT_W-1:0] nxt_idx  = abort_req ? '0
                             : !store_en ? conv_idx_ff
                             : last_conv ? '0 : SLOT_W'(conv_idx_ff + 3'd1);

  // register read selection
  wire [DATA_W-1:0] status_word = {8'h00, irq_stat_ff[IRQ_SEQ], state_ff != ST_IDLE,
                                   3'h0, slot_ff};
  wire [DATA_W-1:0] rd_val =
      (reg_addr_in == OFS_STATUS)   ? status_word :
      (reg_addr_in == OFS_FLAGS)    ? DATA_W'(ccf_ff) :
      (reg_addr_in == OFS_TRIG_CTL) ? DATA_W'(trig_ctl_ff) :
      (reg_addr_in == OFS_FMT_CTL)  ? DATA_W'(fmt_ctl_ff) :
      (reg_addr_in == OFS_CMP_EN)   ? DATA_W'(cmp_en_ff) :
      (reg_addr_in == OFS_IRQ_STAT) ? DATA_W'(irq_stat_ff) :
      (reg_addr_in == OFS_IRQ_MASK) ? DATA_W'(irq_mask_ff) : 16'h0000;

  // result memory hookup
  assign res.wr_en   = store_en;
  assign res.wr_addr = slot_ff;
  assign res.wr_data = res_word;
  assign res.rd_addr = res_idx;

  // sequence controller
  always_comb begin
    nxt_state   = state_ff;
    start_pulse = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_ARMED: begin
        if (!ext_en || trig_event) begin
          nxt_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (!frz_stop_next) begin
          nxt_state   = ST_WAIT;
          start_pulse = 1'b1;
        end
      end
      ST_WAIT: begin
        if (conv_done_in) begin
          nxt_state = !last_conv ? ST_ISSUE : (ext_en ? ST_ARMED : ST_IDLE);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (abort_req) begin
      nxt_state   = wr_start ? ST_ARMED : ST_IDLE;
      start_pulse = 1'b0;
    end
  end

  // control registers
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      trig_ctl_ff <= TRIG_CTL_RST;
      fmt_ctl_ff  <= FMT_CTL_RST;
      cmp_en_ff   <= CMP_EN_RST;
      irq_mask_ff <= IRQ_MASK_RST;
    end else begin
      trig_ctl_ff <= wr_trig ? reg_wdata_in[7:0] : trig_ctl_ff;
      fmt_ctl_ff  <= wr_fmt ? reg_wdata_in[7:0] : fmt_ctl_ff;
      cmp_en_ff   <= wr_cmp ? reg_wdata_in[NUM_SLOTS-1:0] : cmp_en_ff;
      irq_mask_ff <= wr_imask ? reg_wdata_in[1:0] : irq_mask_ff;
    end
  end

  // flags, counters and state
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ccf_ff      <= '0;
      irq_stat_ff <= 2'h0;
      slot_ff     <= '0;
      conv_idx_ff <= '0;
      state_ff    <= ST_IDLE;
    end else begin
      ccf_ff      <= nxt_ccf;
      irq_stat_ff <= nxt_istat;
      slot_ff     <= nxt_slot;
      conv_idx_ff <= nxt_idx;
      state_ff    <= nxt_state;
    end
  end

  // external trigger synchroniser and edge history
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_meta_ff <= ext_trig_in;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
    end
  end

  // output flops
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      conv_start_ff <= 1'b0;
      conv_abort_ff <= 1'b0;
      conv_hold_ff  <= 1'b0;
      dig_buf_ff    <= 1'b0;
      irq_ff        <= 1'b0;
      rd_data_ff    <= '0;
      res_sel_ff    <= 1'b0;
    end else begin
      conv_start_ff <= start_pulse;
      conv_abort_ff <= abort_req;
      conv_hold_ff  <= frz_now && (state_ff == ST_WAIT);
      dig_buf_ff    <= ext_en && trig_src_channel_in;
      irq_ff        <= nxt_irq;
      rd_data_ff    <= reg_rd_in ? rd_val : '0;
      res_sel_ff    <= rd_res;
    end
  end

  // result reads come from the memory's own output register
  assign reg_rdata_out  = res_sel_ff ? res.rd_data : rd_data_ff;
  assign conv_start_out = conv_start_ff;
  assign conv_abort_out = conv_abort_ff;
  assign conv_hold_out  = conv_hold_ff;
  assign dig_buf_en_out = dig_buf_ff;
  assign irq_out        = irq_ff;

  // checks on the controller
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  a_ctl_write_abort: assert property (
    (reg_wr_in && (reg_addr_in == OFS_TRIG_CTL || reg_addr_in == OFS_FMT_CTL))
      |=> conv_abort_out && state_ff == ST_IDLE && !conv_start_out)
    else $error("control write did not abort the sequence");

  a_w1c_flag: assert property (
    (!fast_clr && wr_flags && reg_wdata_in[0] && !set_vec[0]) |=> !ccf_ff[0])
    else $error("write one did not clear flag zero");

  a_fast_no_w1c: assert property (
    (fast_clr && ccf_ff[1] && !clr_rd[1] && !clr_wr[1]) |=> ccf_ff[1])
    else $error("flag one cleared without its access");

  a_read_fast_clr: assert property (
    (fast_clr && reg_rd_in && reg_addr_in == OFS_RES_BASE && !cmp_en_eff[0]
      && !set_vec[0]) |=> !ccf_ff[0])
    else $error("result read did not clear flag zero");

  a_write_fast_clr: assert property (
    (fast_clr && reg_wr_in && reg_addr_in == OFS_RES_BASE && cmp_en_eff[0]
      && !set_vec[0]) |=> !ccf_ff[0])
    else $error("result write did not clear flag zero");

  a_rise_trigger: assert property (
    (state_ff == ST_ARMED && ext_en && !trig_level && trig_pol
      && !trig_prev_ff && trig_sync_ff && !abort_req) |=> state_ff == ST_ISSUE)
    else $error("rising edge did not start the sequence");

  a_edge_hold: assert property (
    (state_ff == ST_ARMED && ext_en && !trig_level
      && trig_prev_ff == trig_sync_ff && !abort_req) |=> state_ff == ST_ARMED)
    else $error("sequence started without a trigger edge");

  a_buffer_enable: assert property (
    (ext_en && trig_src_channel_in) |=> dig_buf_en_out)
    else $error("channel input buffer not enabled");

  a_seq_irq: assert property (
    (irq_stat_ff[IRQ_SEQ] && irq_mask_ff[IRQ_SEQ] && seq_ie) |=> irq_out)
    else $error("sequence interrupt not raised");

  a_cmp_event: assert property (
    (store_en && cmp_en_eff[slot_ff] && conv_match_in) |=> irq_stat_ff[IRQ_CMP])
    else $error("compare event not recorded");

  a_right_justify: assert property (
    (store_en && justify_r) |-> res.wr_data == {6'h00, conv_data_in})
    else $error("right justified result misplaced");

  a_seq_length: assert property (
    (store_en && conv_idx_ff == seq_len - 3'd1) |=> irq_stat_ff[IRQ_SEQ] && conv_idx_ff == 3'h0)
    else $error("sequence did not end at its length");

  a_fixed_slot: assert property (
    (!fifo_mode && state_ff != ST_IDLE && !$past(wr_fmt)) |-> slot_ff == conv_idx_ff)
    else $error("fixed mode slot differs from conversion index");

  a_fifo_wrap: assert property (
    (fifo_mode && store_en && slot_ff == 3'h5) |=> slot_ff == 3'h0)
    else $error("fifo slot did not wrap");

  a_status_slot: assert property (
    (reg_rd_in && reg_addr_in == OFS_STATUS) |=> reg_rdata_out[2:0] == $past(slot_ff))
    else $error("status does not show the slot counter");

  a_start_clears: assert property (
    wr_start |=> slot_ff == 3'h0 ##1 (slot_ff == 3'h0 || $past(store_en)))
    else $error("new start did not clear the slot counter");

  a_fifo_no_cmp: assert property (
    (fifo_mode && !irq_stat_ff[IRQ_CMP] && !wr_fmt) |=> !irq_stat_ff[IRQ_CMP])
    else $error("compare flagged while in fifo mode");

  a_freeze_now: assert property (
    (state_ff == ST_ISSUE && freeze_in && frz_mode[1] && !abort_req)
      |=> !conv_start_out && state_ff == ST_ISSUE)
    else $error("conversion issued during freeze");

  a_freeze_run: assert property (
    (state_ff == ST_ISSUE && frz_mode == FRZ_RUN && !abort_req) |=> conv_start_out)
    else $error("conversion held without freeze");

endmodule

// ==== hdl/atc_pkg.sv ====
package atc_pkg;

  // bus and storage geometry
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 16;
  localparam int NUM_SLOTS = 6;
  localparam int SLOT_W    = 3;
  localparam int RES_BITS  = 10;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_TRIG_CTL = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_FMT_CTL  = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_CMP_EN   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_START    = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_RES_BASE = 5'h10;

  // trigger_and_irq_control fields
  localparam int BIT_FAST_CLR = 6;
  localparam int BIT_LEVEL    = 4;
  localparam int BIT_POL      = 3;
  localparam int BIT_EXT_TRIG = 2;
  localparam int BIT_SEQ_IE   = 1;
  localparam int BIT_CMP_IE   = 0;

  // result_format_sequence_control fields
  localparam int BIT_JUSTIFY = 7;
  localparam int SEQ_MSB     = 6;
  localparam int SEQ_LSB     = 3;
  localparam int BIT_FIFO    = 2;
  localparam int FRZ_MSB     = 1;
  localparam int FRZ_LSB     = 0;

  // interrupt status and mask bits
  localparam int IRQ_SEQ = 0;
  localparam int IRQ_CMP = 1;

  // reset values
  localparam logic [7:0] TRIG_CTL_RST = 8'h00;
  localparam logic [7:0] FMT_CTL_RST  = 8'h20;
  localparam logic [5:0] CMP_EN_RST   = 6'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  typedef enum logic [1:0] {
    FRZ_RUN    = 2'b00,
    FRZ_RSVD   = 2'b01,
    FRZ_FINISH = 2'b10,
    FRZ_NOW    = 2'b11
  } atc_frz_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_ISSUE = 2'b10,
    ST_WAIT  = 2'b11
  } atc_state_t;

  // sequence length: 0 and above 6 mean six conversions
  function automatic logic [SLOT_W-1:0] atc_seq_len(input logic [3:0] code);
    atc_seq_len = (code == 4'h0 || code > 4'h6) ? 3'h6 : code[2:0];
  endfunction

  // one bit per result slot
  function automatic logic [NUM_SLOTS-1:0] atc_onehot(input logic [SLOT_W-1:0] idx);
    atc_onehot = NUM_SLOTS'(1) << idx;
  endfunction

endpackage

// ==== hdl/atc_res_if.sv ====
`timescale 1ns/1ps
interface atc_res_if #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 16,
  parameter int AW    = 3
);
  logic             wr_en;
  logic [AW-1:0]    wr_addr;
  logic [WIDTH-1:0] wr_data;
  logic [AW-1:0]    rd_addr;
  logic [WIDTH-1:0] rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== hdl/atc_result_mem.sv ====
`timescale 1ns/1ps
module atc_result_mem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 16
) (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  atc_res_if.mem    res
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_ff;

  // result storage, written once per finished conversion
  always_ff @(posedge core_clk_in) begin
    if (res.wr_en) begin
      mem_ff[res.wr_addr] <= res.wr_data;
    end
  end

  // registered read port, unused addresses read zero
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= (res.rd_addr < DEPTH) ? mem_ff[res.rd_addr] : '0;
    end
  end

  assign res.rd_data = rd_ff;
endmodule

// ==== dv/test_adc_trigger_result_control.sv ====
`timescale 1ns/1ps
module test_adc_trigger_result_control
  import atc_pkg::*;
;
  typedef struct {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] exp;
    logic              abt;
  } atc_tb_row_t;

  logic                core_clk_in, reset_in, reg_wr_in, reg_rd_in, ext_trig_in;
  logic                trig_src_channel_in, freeze_in, conv_done_in, conv_match_in;
  logic [ADDR_W-1:0]   reg_addr_in;
  logic [DATA_W-1:0]   reg_wdata_in, reg_rdata_out, v;
  logic [RES_BITS-1:0] conv_data_in;
  logic                conv_start_out, conv_abort_out, conv_hold_out, dig_buf_en_out, irq_out;
  logic                seen;
  int                  n_mismatch, checked;

  // ordinary register cases: reset values, write then read back, abort pulse
  atc_tb_row_t rows [10] = '{
    '{1'b0, 5'h02, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, 5'h03, 16'h0000, 16'h0020, 1'b0},
    '{1'b0, 5'h04, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, 5'h07, 16'h0000, 16'h0000, 1'b0},
    '{1'b0, 5'h08, 16'h0000, 16'h0000, 1'b0},
    '{1'b1, 5'h02, 16'h001f, 16'h001f, 1'b1},
    '{1'b1, 5'h03, 16'h00ff, 16'h00ff, 1'b1},
    '{1'b1, 5'h08, 16'h0055, 16'h0000, 1'b0},
    '{1'b1, 5'h07, 16'h0003, 16'h0003, 1'b0},
    '{1'b1, 5'h02, 16'h0000, 16'h0000, 1'b1}};

  atc_ctl dut (
    .core_clk_in        (core_clk_in),
    .reset_in           (reset_in),
    .reg_addr_in        (reg_addr_in),
    .reg_wdata_in       (reg_wdata_in),
    .reg_wr_in          (reg_wr_in),
    .reg_rd_in          (reg_rd_in),
    .reg_rdata_out      (reg_rdata_out),
    .ext_trig_in        (ext_trig_in),
    .trig_src_channel_in(trig_src_channel_in),
    .freeze_in          (freeze_in),
    .conv_done_in       (conv_done_in),
    .conv_data_in       (conv_data_in),
    .conv_match_in      (conv_match_in),
    .conv_start_out     (conv_start_out),
    .conv_abort_out     (conv_abort_out),
    .conv_hold_out      (conv_hold_out),
    .dig_buf_en_out     (dig_buf_en_out),
    .irq_out            (irq_out)
  );

  // clock generation
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // one-cycle read strobe, data sampled in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    logic [DATA_W-1:0] q;
    rd(a, q);
    chk(nm, e, q);
  endtask

  // watch for a start pulse over n cycles, return on an edge so callers drive there
  task automatic watch(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(posedge core_clk_in);
      #1;
      if (conv_start_out === 1'b1) s = 1'b1;
    end
    @(posedge core_clk_in);
  endtask

  // wait for a start, then answer with one done pulse
  task automatic conv(input logic [RES_BITS-1:0] d, input logic m);
    int i;
    #1;
    for (i = 0; i < 40 && conv_start_out !== 1'b1; i++) begin
      @(posedge core_clk_in);
      #1;
    end
    chk("start", 16'h1, 16'(conv_start_out));
    repeat (3) @(posedge core_clk_in);
    conv_done_in  <= 1'b1;
    conv_data_in  <= d;
    conv_match_in <= m;
    @(posedge core_clk_in);
    conv_done_in <= 1'b0;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_mismatch++;
    final_report();
  end

  initial begin
    reset_in = 1'b1; reg_wr_in = 1'b0; reg_rd_in = 1'b0; reg_addr_in = '0;
    reg_wdata_in = '0; ext_trig_in = 1'b0; trig_src_channel_in = 1'b0;
    freeze_in = 1'b0; conv_done_in = 1'b0; conv_data_in = '0; conv_match_in = 1'b0;
    n_mismatch = 0; checked = 0;
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
        #1;
        chk("abort", 16'(rows[i].abt), 16'(conv_abort_out));
      end
      rc(rows[i].addr, rows[i].exp, "reg");
    end
    $display("test registers done");
    // two-conversion fixed sequence, right justified
    wr(OFS_FMT_CTL, 16'h0090);
    wr(OFS_START, 16'h0000);
    conv(10'h2a5, 1'b0);
    conv(10'h15a, 1'b0);
    repeat (2) @(posedge core_clk_in);
    rc(5'h10, 16'h02a5, "res0");
    rc(5'h11, 16'h015a, "res1");
    rc(OFS_FLAGS, 16'h0003, "flags");
    rc(OFS_IRQ_STAT, 16'h0001, "irqst");
    chk("irq", 16'h0, 16'(irq_out));
    wr(OFS_TRIG_CTL, 16'h0002);
    repeat (2) @(posedge core_clk_in);
    chk("irq", 16'h1, 16'(irq_out));
    wr(OFS_IRQ_STAT, 16'h0001);
    repeat (2) @(posedge core_clk_in);
    chk("irq", 16'h0, 16'(irq_out));
    $display("test sequence done");
    // flag clearing without and with fast clear
    rc(OFS_FLAGS, 16'h0003, "flags");
    wr(OFS_FLAGS, 16'h0001);
    rc(OFS_FLAGS, 16'h0002, "flags");
    wr(OFS_TRIG_CTL, 16'h0040);
    rc(5'h11, 16'h015a, "res1");
    rc(OFS_FLAGS, 16'h0000, "flags");
    $display("test flag clear done");
    // compare conversion, left justified, cleared by result write
    wr(OFS_CMP_EN, 16'h0001);
    wr(OFS_FMT_CTL, 16'h0008);
    wr(OFS_TRIG_CTL, 16'h0041);
    wr(OFS_START, 16'h0000);
    conv(10'h3ff, 1'b1);
    repeat (2) @(posedge core_clk_in);
    rc(5'h10, 16'hffc0, "res0");
    rc(OFS_IRQ_STAT, 16'h0003, "irqst");
    chk("irq", 16'h1, 16'(irq_out));
    wr(5'h10, 16'h0000);
    rc(OFS_FLAGS, 16'h0000, "flags");
    wr(OFS_IRQ_STAT, 16'h0003);
    $display("test compare done");
    // fifo mode: counter keeps its place, start clears it, compare off
    wr(OFS_CMP_EN, 16'h003f);
    wr(OFS_FMT_CTL, 16'h000c);
    wr(OFS_START, 16'h0000);
    conv(10'h001, 1'b1);
    repeat (2) @(posedge core_clk_in);
    rd(OFS_STATUS, v);
    chk("slot", 16'h1, 16'(v[2:0]));
    rc(OFS_IRQ_STAT, 16'h0001, "irqst");
    chk("irq", 16'h0, 16'(irq_out));
    wr(OFS_START, 16'h0000);
    rd(OFS_STATUS, v);
    chk("slot", 16'h0, 16'(v[2:0]));
    $display("test fifo done");
    // trigger sensitivity, all four codes
    wr(OFS_FMT_CTL, 16'h0008);
    trig_src_channel_in <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      ext_trig_in <= m[0];
      repeat (6) @(posedge core_clk_in);
      wr(OFS_TRIG_CTL, 16'(m * 8 + 4));
      repeat (2) @(posedge core_clk_in);
      chk("dbuf", 16'h1, 16'(dig_buf_en_out));
      wr(OFS_START, 16'h0000);
      watch(10, seen);
      chk("lvl", 16'(m[1]), 16'(seen));
      if (!m[1]) begin
        ext_trig_in <= ~m[0];
        repeat (4) @(posedge core_clk_in);
        ext_trig_in <= m[0];
        watch(12, seen);
        chk("edge", 16'h1, 16'(seen));
      end
    end
    trig_src_channel_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    chk("dbuf", 16'h0, 16'(dig_buf_en_out));
    wr(OFS_TRIG_CTL, 16'h0000);
    $display("test trigger done");
    // length code zero gives six conversions; fifo slot wraps back to zero
    wr(OFS_IRQ_STAT, 16'h0003);
    wr(OFS_FMT_CTL, 16'h0004);
    wr(OFS_START, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      conv(10'(k), 1'b0);
    end
    repeat (2) @(posedge core_clk_in);
    rc(OFS_FLAGS, 16'h003f, "flags");
    rc(5'h15, 16'h0140, "res5");
    rc(OFS_STATUS, 16'h0080, "status");
    $display("test length done");
    // freeze codes with breakpoint active
    @(posedge core_clk_in);
    freeze_in <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(OFS_FMT_CTL, 16'(8 + f));
      wr(OFS_START, 16'h0000);
      watch(10, seen);
      chk("frz", 16'(!f[1]), 16'(seen));
    end
    freeze_in <= 1'b0;
    wr(OFS_FMT_CTL, 16'h000b);
    wr(OFS_START, 16'h0000);
    watch(6, seen);
    freeze_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk("hold", 16'h1, 16'(conv_hold_out));
    freeze_in <= 1'b0;
    $display("test freeze done");
    final_report();
  end
endmodule
